//--- rtl/dtq_pkg.sv
// ----------------------------------------------------------------
// shared constants for the trigger qualifier
// ----------------------------------------------------------------
package dtq_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_TRIG_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMP_CTRL  = 8'h01;
  localparam logic [7:0] OFS_STATUS    = 8'h02;

  // trigger control field positions
  localparam int unsigned TRG_TYPE_BIT  = 7;
  localparam int unsigned TRG_BEGIN_BIT = 6;
  localparam int unsigned TRG_MODE_LSB  = 0;
  localparam int unsigned TRG_MODE_W    = 4;

  // bits kept by a trigger control write; bits 4 and 5 always read back as zero
  localparam logic [7:0] TRIG_CTRL_MASK  = 8'hCF;
  localparam logic [7:0] TRIG_CTRL_RESET = 8'h40;

  // compare control field positions
  localparam int unsigned CMP_A_QEN_BIT = 0;
  localparam int unsigned CMP_A_DIR_BIT = 1;
  localparam int unsigned CMP_B_QEN_BIT = 2;
  localparam int unsigned CMP_B_DIR_BIT = 3;
  localparam int unsigned CMP_ARM_BIT   = 7;
  localparam logic [3:0]  CMP_CTRL_RESET = 4'h0;

  // status field positions
  localparam int unsigned STS_ARMED_BIT   = 0;
  localparam int unsigned STS_TRIG_BIT    = 1;
  localparam int unsigned STS_CAPTURE_BIT = 2;
  localparam int unsigned STS_TAG_BIT     = 3;
  localparam int unsigned STS_POST_BIT    = 4;

  // trigger mode codes; only MODE_EVT_A and MODE_EVT_A_OR_B are event-only
  localparam logic [3:0] MODE_A_ONLY     = 4'h0;
  localparam logic [3:0] MODE_A_OR_B     = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B   = 4'h2;
  localparam logic [3:0] MODE_EVT_A      = 4'h8;
  localparam logic [3:0] MODE_EVT_A_OR_B = 4'h9;

  // capture sequencer states
  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_PRE,
    CAP_POST
  } dtq_cap_e;

endpackage

//--- rtl/dtq_cmp_qualify.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// read/write qualification of one address comparator
// ----------------------------------------------------------------
module dtq_cmp_qualify (
  // comparator result and bus direction
  input  wire logic addr_equal_in,
  input  wire logic bus_read_in,
  // qualification settings
  input  wire logic dir_qualify_en_in,
  input  wire logic dir_value_in,
  // qualified match
  output wire logic match_out
);

  // direction agrees when a read meets value 1 or a write meets value 0
  // value 1 reads, 0 writes
  wire logic dir_agree;
  assign dir_agree = ~(bus_read_in ^ dir_value_in);

  // with qualification off neither direction nor value reaches the match
  assign match_out = addr_equal_in & (~dir_qualify_en_in | dir_agree);

endmodule

`default_nettype wire

//--- rtl/dtq_trigger_qualifier.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dtq_trigger_qualifier (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // core bus observation
  input  wire logic       bus_cycle_in,
  input  wire logic       bus_read_in,
  input  wire logic       bus_fetch_in,
  input  wire logic       addr_equal_a_in,
  input  wire logic       addr_equal_b_in,
  // opcode tracking
  input  wire logic       opcode_exec_in,
  input  wire logic       fetch_flush_in,
  // capture fifo control
  input  wire logic       fifo_full_in,
  output logic            capture_en_out,
  output logic            trigger_out,
  output logic            armed_out,
  output logic            match_a_out,
  output logic            match_b_out
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]           trig_ctrl_q;
  logic [3:0]           cmp_ctrl_q;
  logic                 triggered_q;
  logic                 tag_pending_q;
  logic                 fetch_q;
  logic                 a_seen_q;
  dtq_pkg::dtq_cap_e    state_q;
  dtq_pkg::dtq_cap_e    state_d;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire logic sel_trig;
  wire logic sel_cmp;
  wire logic sel_sts;
  wire logic wr_trig;
  wire logic wr_cmp;
  wire logic arm_req;
  wire logic disarm_req;

  // address decode, unmapped offsets read as zero and ignore writes
  assign sel_trig = (reg_addr_in == dtq_pkg::OFS_TRIG_CTRL);
  assign sel_cmp  = (reg_addr_in == dtq_pkg::OFS_CMP_CTRL);
  assign sel_sts  = (reg_addr_in == dtq_pkg::OFS_STATUS);

  assign wr_trig = reg_wr_in & sel_trig & ~armed_out;
  assign wr_cmp  = reg_wr_in & sel_cmp;

  // the arm bit in the compare control starts or stops a run
  assign arm_req    = wr_cmp & reg_wdata_in[dtq_pkg::CMP_ARM_BIT];
  assign disarm_req = wr_cmp & ~reg_wdata_in[dtq_pkg::CMP_ARM_BIT];

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire logic       tag_sel;
  wire logic       begin_sel;
  wire logic [3:0] mode;
  wire logic       event_only;
  wire logic       begin_eff;

  assign tag_sel   = trig_ctrl_q[dtq_pkg::TRG_TYPE_BIT];
  assign begin_sel = trig_ctrl_q[dtq_pkg::TRG_BEGIN_BIT];
  assign mode      = trig_ctrl_q[dtq_pkg::TRG_MODE_LSB +: dtq_pkg::TRG_MODE_W];

  assign event_only = (mode == dtq_pkg::MODE_EVT_A) | (mode == dtq_pkg::MODE_EVT_A_OR_B);
  assign begin_eff  = begin_sel | event_only;

  // ----------------------------------------------------------------
  // comparator qualification
  // ----------------------------------------------------------------
  wire logic qual_a;
  wire logic qual_b;

  dtq_cmp_qualify u_qual_a (
    .addr_equal_in     (addr_equal_a_in),
    .bus_read_in       (bus_read_in),
    .dir_qualify_en_in (cmp_ctrl_q[dtq_pkg::CMP_A_QEN_BIT]),
    .dir_value_in      (cmp_ctrl_q[dtq_pkg::CMP_A_DIR_BIT]),
    .match_out         (qual_a)
  );

  dtq_cmp_qualify u_qual_b (
    .addr_equal_in     (addr_equal_b_in),
    .bus_read_in       (bus_read_in),
    .dir_qualify_en_in (cmp_ctrl_q[dtq_pkg::CMP_B_QEN_BIT]),
    .dir_value_in      (cmp_ctrl_q[dtq_pkg::CMP_B_DIR_BIT]),
    .match_out         (qual_b)
  );

  // sample match once per bus cycle
  // matches are registered so a glitching comparator cannot fire twice
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      match_a_out <= 1'b0;
      match_b_out <= 1'b0;
      fetch_q     <= 1'b0;
    end else begin
      match_a_out <= bus_cycle_in & qual_a;
      match_b_out <= bus_cycle_in & qual_b;
      fetch_q     <= bus_cycle_in & bus_fetch_in;
    end
  end

  // ----------------------------------------------------------------
  // trigger combination
  // ----------------------------------------------------------------
  wire logic hit_a_or_b;
  wire logic hit_a_then_b;
  wire logic hit;
  wire logic running;

  assign running      = (state_q != dtq_pkg::CAP_IDLE);
  assign hit_a_or_b   = match_a_out | match_b_out;
  assign hit_a_then_b = a_seen_q & match_b_out;

  // unknown mode codes never produce a hit
  assign hit = ((mode == dtq_pkg::MODE_A_ONLY) & match_a_out)
             | ((mode == dtq_pkg::MODE_EVT_A) & match_a_out)
             | ((mode == dtq_pkg::MODE_A_OR_B) & hit_a_or_b)
             | ((mode == dtq_pkg::MODE_EVT_A_OR_B) & hit_a_or_b)
             | ((mode == dtq_pkg::MODE_A_THEN_B) & hit_a_then_b);

  // first stage of the A-then-B sequence, dropped when the run ends
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      a_seen_q <= 1'b0;
    end else begin
      a_seen_q <= running & (a_seen_q | match_a_out);
    end
  end

  // ----------------------------------------------------------------
  // opcode tracking
  // ----------------------------------------------------------------
  wire logic tag_set;
  wire logic tag_fire;
  wire logic force_fire;
  wire logic fire;

  // a hit on an opcode fetch is only a candidate until it executes
  assign tag_set = running & tag_sel & hit & fetch_q;

  assign tag_fire = tag_sel & tag_pending_q & opcode_exec_in;

  assign force_fire = ~tag_sel & hit;

  assign fire = running & (tag_fire | force_fire);

  // a new tag wins over a clear in the same cycle; a flush discards
  // prefetched opcodes that will never run
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tag_pending_q <= 1'b0;
    end else if (tag_set) begin
      tag_pending_q <= 1'b1;
    end else if (fetch_flush_in | opcode_exec_in | ~running) begin
      tag_pending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // capture sequencer
  // ----------------------------------------------------------------
  // pre-trigger capture only in end trace; begin trace waits
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dtq_pkg::CAP_IDLE: begin
        if (arm_req) begin
          state_d = dtq_pkg::CAP_PRE;
        end
      end
      dtq_pkg::CAP_PRE: begin
        if (disarm_req) begin
          state_d = dtq_pkg::CAP_IDLE;
        end else if (fire & begin_eff) begin
          state_d = dtq_pkg::CAP_POST;
        end else if (fire) begin
          state_d = dtq_pkg::CAP_IDLE;
        end
      end
      dtq_pkg::CAP_POST: begin
        // begin trace stops when the fifo has filled
        if (disarm_req | fifo_full_in) begin
          state_d = dtq_pkg::CAP_IDLE;
        end
      end
      default: begin
        state_d = dtq_pkg::CAP_IDLE;
      end
    endcase
  end

  // capture enable covers circular fill before trigger in end trace
  wire logic capture_d;
  assign capture_d = (state_d == dtq_pkg::CAP_POST)
                   | ((state_d == dtq_pkg::CAP_PRE) & ~begin_eff);

  // sequencer state and its registered outputs
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q        <= dtq_pkg::CAP_IDLE;
      armed_out      <= 1'b0;
      capture_en_out <= 1'b0;
      trigger_out    <= 1'b0;
    end else begin
      state_q        <= state_d;
      armed_out      <= (state_d != dtq_pkg::CAP_IDLE);
      capture_en_out <= capture_d;
      trigger_out    <= fire;
    end
  end

  // sticky trigger flag: a trigger wins over the rearm clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      triggered_q <= 1'b0;
    end else if (fire) begin
      triggered_q <= 1'b1;
    end else if (arm_req & ~armed_out) begin
      triggered_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // bits 4 and 5 held at zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_ctrl_q <= dtq_pkg::TRIG_CTRL_RESET;
    end else if (wr_trig) begin
      trig_ctrl_q <= reg_wdata_in & dtq_pkg::TRIG_CTRL_MASK;
    end
  end

  // qualifier bits may change mid-run; they act on the next bus cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_ctrl_q <= dtq_pkg::CMP_CTRL_RESET;
    end else if (wr_cmp) begin
      cmp_ctrl_q <= reg_wdata_in[3:0];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire logic [7:0] cmp_rd;
  wire logic [7:0] sts_rd;
  wire logic [7:0] rd_mux;

  assign cmp_rd = {armed_out, 3'h0, cmp_ctrl_q};
  assign sts_rd = {3'h0, (state_q == dtq_pkg::CAP_POST), tag_pending_q,
                   capture_en_out, triggered_q, armed_out};

  assign rd_mux = sel_trig ? trig_ctrl_q
                : sel_cmp  ? cmp_rd
                : sel_sts  ? sts_rd
                : 8'h00;

  // read data stand one cycle after the strobe and read zero otherwise
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ctrl_write_lock: assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_wr_in && sel_trig && armed_out) |=> $stable(trig_ctrl_q))
    else $error("control changed while armed");

  a_ctrl_write_take: assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_wr_in && sel_trig && !armed_out)
      |=> trig_ctrl_q == ($past(reg_wdata_in) & dtq_pkg::TRIG_CTRL_MASK))
    else $error("control write lost while disarmed");

  a_zero_bits_read: assert property (@(posedge mclk_in) disable iff (rst_in)
    $past(reg_rd_in && sel_trig) |-> reg_rdata_out[5:4] == 2'b00)
    else $error("control bits 4 and 5 not zero");

  a_cmp_a_free: assert property (@(posedge mclk_in) disable iff (rst_in)
    (bus_cycle_in && !cmp_ctrl_q[0]) |=> match_a_out == $past(addr_equal_a_in))
    else $error("comparator A used direction while disabled");

  a_cmp_a_dir: assert property (@(posedge mclk_in) disable iff (rst_in)
    (bus_cycle_in && cmp_ctrl_q[0] && (bus_read_in != cmp_ctrl_q[1])) |=> !match_a_out)
    else $error("comparator A matched wrong direction");

  a_cmp_b_free: assert property (@(posedge mclk_in) disable iff (rst_in)
    (bus_cycle_in && !cmp_ctrl_q[2]) |=> match_b_out == $past(addr_equal_b_in))
    else $error("comparator B used direction while disabled");

  a_cmp_b_read: assert property (@(posedge mclk_in) disable iff (rst_in)
    (bus_cycle_in && cmp_ctrl_q[2] && cmp_ctrl_q[3] && !bus_read_in) |=> !match_b_out)
    else $error("comparator B matched a write in read mode");

  a_cmp_b_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    (bus_cycle_in && cmp_ctrl_q[2] && !cmp_ctrl_q[3] && addr_equal_b_in && !bus_read_in)
      |=> match_b_out)
    else $error("comparator B missed a write in write mode");

  a_match_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
    !bus_cycle_in |=> !match_a_out && !match_b_out)
    else $error("match outside a bus cycle");

  a_tag_needs_exec: assert property (@(posedge mclk_in) disable iff (rst_in)
    (tag_sel && !opcode_exec_in) |=> !trigger_out)
    else $error("tag trigger without execution");

  a_force_trigger: assert property (@(posedge mclk_in) disable iff (rst_in)
    (running && !tag_sel && hit) |=> trigger_out ##1 !armed_out || capture_en_out)
    else $error("force trigger missing");

  a_begin_capture: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == dtq_pkg::CAP_PRE && begin_eff && fire && !disarm_req)
      |=> capture_en_out && armed_out && trigger_out)
    else $error("begin trace did not start capture");

  a_end_capture: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == dtq_pkg::CAP_PRE && !begin_eff && fire)
      |=> !capture_en_out && !armed_out)
    else $error("end trace did not stop capture");

  a_end_circular: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == dtq_pkg::CAP_PRE && !begin_eff && !fire && !disarm_req) |=> capture_en_out)
    else $error("end trace not capturing before trigger");

  a_event_begin: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == dtq_pkg::CAP_PRE && event_only && !fire) |=> !capture_en_out)
    else $error("event-only mode captured before trigger");

endmodule

`default_nettype wire

//--- sim/dtq_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// core bus and capture fifo stand-in
// ----------------------------------------------------------------
module dtq_core_model #(
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // requests from the bench
  input  wire logic go_in,
  input  wire logic read_in,
  input  wire logic fetch_in,
  input  wire logic hit_a_in,
  input  wire logic hit_b_in,
  input  wire logic exec_in,
  input  wire logic flush_in,
  // capture enable from the block
  input  wire logic capture_en_in,
  // core bus and fifo side
  output logic      bus_cycle_out,
  output logic      bus_read_out,
  output logic      bus_fetch_out,
  output logic      eq_a_out,
  output logic      eq_b_out,
  output logic      exec_out,
  output logic      flush_out,
  output wire logic fifo_full_out
);
  logic [7:0] fill_q;

  // one bus cycle per request; between cycles the qualifiers wander
  // so that a block trusting stale values is caught
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_cycle_out <= 1'b0;
      bus_read_out  <= 1'b0;
      bus_fetch_out <= 1'b0;
      eq_a_out      <= 1'b0;
      eq_b_out      <= 1'b0;
      exec_out      <= 1'b0;
      flush_out     <= 1'b0;
    end else begin
      bus_cycle_out <= go_in;
      bus_read_out  <= go_in ? read_in : ~bus_read_out;
      bus_fetch_out <= go_in ? fetch_in : ~bus_fetch_out;
      eq_a_out      <= go_in ? hit_a_in : ~eq_a_out;
      eq_b_out      <= go_in ? hit_b_in : ~eq_b_out;
      exec_out      <= exec_in;
      flush_out     <= flush_in;
    end
  end

  // fill counter; restarts when capture stops, saturates when full
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fill_q <= 8'h00;
    end else begin
      fill_q <= !capture_en_in ? 8'h00 : (fifo_full_out ? fill_q : fill_q + 8'h01);
    end
  end
  assign fifo_full_out = (fill_q >= DEPTH[7:0]);
endmodule

`default_nettype wire

//--- sim/test_dtq_trigger_qualifier.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// self-checking bench for the trigger qualifier
// ----------------------------------------------------------------
module test_dtq_trigger_qualifier;
  logic       mclk_in, rst_in, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, rd_val;
  logic       go, rd_c, fetch, hit_a, hit_b, exec_r, flush;
  wire logic  bus_cycle, bus_read, bus_fetch, eq_a, eq_b, op_exec, op_flush, fifo_full;
  wire logic  capture_en, trigger, armed, match_a, match_b;
  wire logic [7:0] reg_rdata;
  int         n_fail, checks, cycles, ma_at, mb_at, trig_at;

  dtq_core_model #(.DEPTH(4)) i_core (.mclk_in(mclk_in), .rst_in(rst_in), .go_in(go),
    .read_in(rd_c), .fetch_in(fetch), .hit_a_in(hit_a), .hit_b_in(hit_b), .exec_in(exec_r),
    .flush_in(flush), .capture_en_in(capture_en), .bus_cycle_out(bus_cycle),
    .bus_read_out(bus_read), .bus_fetch_out(bus_fetch), .eq_a_out(eq_a), .eq_b_out(eq_b),
    .exec_out(op_exec), .flush_out(op_flush), .fifo_full_out(fifo_full));

  dtq_trigger_qualifier i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .bus_cycle_in(bus_cycle), .bus_read_in(bus_read),
    .bus_fetch_in(bus_fetch), .addr_equal_a_in(eq_a), .addr_equal_b_in(eq_b),
    .opcode_exec_in(op_exec), .fetch_flush_in(op_flush), .fifo_full_in(fifo_full),
    .capture_en_out(capture_en), .trigger_out(trigger), .armed_out(armed),
    .match_a_out(match_a), .match_b_out(match_b));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    reg_read(a, rd_val);
    check("register read", exp, rd_val);
  endtask

  // one request to the core model, then note when match and trigger pulse
  task automatic pulse(input logic g, r, f, a, b, x, fl);
    @(posedge mclk_in);
    go <= g; rd_c <= r; fetch <= f; hit_a <= a; hit_b <= b; exec_r <= x; flush <= fl;
    @(posedge mclk_in);
    go <= 1'b0; exec_r <= 1'b0; flush <= 1'b0;
    ma_at = 0; mb_at = 0; trig_at = 0;
    for (int i = 2; i <= 5; i++) begin
      @(posedge mclk_in);
      #1;
      if (match_a === 1'b1 && ma_at == 0) ma_at = i;
      if (match_b === 1'b1 && mb_at == 0) mb_at = i;
      if (trigger === 1'b1 && trig_at == 0) trig_at = i;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("armed", 8'h00, armed);
    check("capture", 8'h00, capture_en);
    read_check(8'h00, 8'h40); // readable reset value
    @(posedge mclk_in);
    #1;
    check("rdata after read", 8'h00, reg_rdata);
    read_check(8'h01, 8'h00);
    read_check(8'h02, 8'h00);
    read_check(8'h05, 8'h00);
  endtask

  task automatic t_ctrl_bits();
    reg_write(8'h00, 8'hFF);
    read_check(8'h00, 8'hCF); // bits four five zero
    reg_write(8'h01, 8'h80);
    check("armed", 8'h01, armed);
    reg_write(8'h00, 8'h00);
    read_check(8'h00, 8'hCF); // armed write ignored
    reg_write(8'h01, 8'h00);
    reg_write(8'h00, 8'h30);
    read_check(8'h00, 8'h00); // written ones read zero
  endtask

  task automatic t_dir();
    logic sel_b, qen, dir, rd;
    logic [1:0] exp_at;
    for (int k = 0; k < 16; k++) begin
      {sel_b, qen, dir, rd} = k[3:0];
      reg_write(8'h01, sel_b ? {4'h0, dir, qen, 2'b00} : {6'h00, dir, qen});
      pulse(1'b1, rd, 1'b0, !sel_b, sel_b, 1'b0, 1'b0);
      exp_at = (!qen || dir == rd) ? 2'd2 : 2'd0;
      if (!sel_b) check("match a at", exp_at, ma_at[7:0]); // direction qualify a
      if (sel_b) check("match b at", exp_at, mb_at[7:0]); // direction value b
      check("idle match", 8'h00, sel_b ? ma_at[7:0] : mb_at[7:0]); // other comparator, address not hit
      check("unarmed trigger", 8'h00, trig_at[7:0]); // not armed
    end
    reg_write(8'h01, 8'h00);
  endtask

  task automatic t_force_begin();
    int n;
    reg_write(8'h00, 8'h40);
    reg_write(8'h01, 8'h80);
    check("capture before trigger", 8'h00, capture_en); // begin waits
    pulse(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    check("match a at", 8'h02, ma_at[7:0]); // force access
    check("trigger at", 8'h03, trig_at[7:0]); // force access
    check("capture after trigger", 8'h01, capture_en); // begin starts
    n = 0;
    while (armed === 1'b1 && n < 20) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    check("armed after full", 8'h00, armed); // fifo full ends
    check("capture after full", 8'h00, capture_en); // fifo full ends
  endtask

  task automatic t_end_trace();
    reg_write(8'h00, 8'h00);
    reg_write(8'h01, 8'h80);
    check("capture at arm", 8'h01, capture_en); // circular fill
    repeat (10) @(posedge mclk_in);
    #1;
    check("armed while full", 8'h01, armed); // wraps over full
    pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    check("trigger at", 8'h03, trig_at[7:0]); // trigger ends
    check("armed after trigger", 8'h00, armed); // trigger ends
    check("capture after trigger", 8'h00, capture_en); // trigger ends
  endtask

  task automatic t_event();
    reg_write(8'h00, 8'h09);
    reg_write(8'h01, 8'h80);
    repeat (2) @(posedge mclk_in);
    #1;
    check("capture before trigger", 8'h00, capture_en); // begin forced
    pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    check("trigger at", 8'h03, trig_at[7:0]); // begin forced
    check("capture after trigger", 8'h01, capture_en); // begin forced
    reg_write(8'h01, 8'h00);
    check("armed after disarm", 8'h00, armed);
  endtask

  task automatic t_tag();
    reg_write(8'h00, 8'hC0);
    reg_write(8'h01, 8'h80);
    pulse(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    check("match a at", 8'h02, ma_at[7:0]);
    check("trigger on fetch", 8'h00, trig_at[7:0]); // waits execution
    pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    check("trigger after flush", 8'h00, trig_at[7:0]); // flushed opcode
    pulse(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    // execute reaches the block one cycle after the request, trigger one later
    pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    check("trigger at", 8'h02, trig_at[7:0]); // executed opcode
    check("capture after trigger", 8'h01, capture_en); // executed opcode
    reg_write(8'h01, 8'h00);
  endtask

  // sequence mode: B counts only after an earlier A match
  task automatic t_a_then_b();
    reg_write(8'h00, 8'h42);
    reg_write(8'h01, 8'h80);
    pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    check("b before a", 8'h00, trig_at[7:0]); // force access
    pulse(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    check("a alone", 8'h00, trig_at[7:0]); // force access
    pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    check("b after a", 8'h03, trig_at[7:0]); // force access
    check("capture after sequence", 8'h01, capture_en); // begin starts
    reg_write(8'h01, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  always #25 mclk_in = ~mclk_in;

  // the whole run needs well under a thousand cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    mclk_in = 1'b0; rst_in = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; go = 1'b0; rd_c = 1'b0; fetch = 1'b0;
    hit_a = 1'b0; hit_b = 1'b0; exec_r = 1'b0; flush = 1'b0;
    n_fail = 0; checks = 0; cycles = 0;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    t_reset();
    t_ctrl_bits();
    t_dir();
    t_force_begin();
    t_end_trace();
    t_event();
    t_tag();
    t_a_then_b();
    wrap_up();
  end
endmodule

`default_nettype wire
